// [rtl/serial_regs_pkg.sv]
`default_nettype none
package serial_regs_pkg;

  localparam int          NUM_CHAN      = 2;
  localparam int          PEND_W        = 6;

  // Write slots.
  localparam logic [3:0]  IDX_CMD       = 4'h0;
  localparam logic [3:0]  IDX_VECTOR    = 4'h2;
  localparam logic [3:0]  IDX_RX_PARAM  = 4'h3;
  localparam logic [3:0]  IDX_MODE      = 4'h4;
  localparam logic [3:0]  IDX_TX_PARAM  = 4'h5;
  localparam logic [3:0]  IDX_FEATURE   = 4'h7;
  localparam logic [3:0]  IDX_TX_BUF    = 4'h8;
  localparam logic [3:0]  IDX_MASTER    = 4'h9;
  localparam logic [3:0]  IDX_MISC      = 4'hA;
  localparam logic [3:0]  IDX_RATE_LO   = 4'hC;
  localparam logic [3:0]  IDX_RATE_HI   = 4'hD;
  localparam logic [3:0]  IDX_EXT_EN    = 4'hF;

  // Read slots.
  localparam logic [3:0]  RD_STATUS     = 4'h0;
  localparam logic [3:0]  RD_SPECIAL    = 4'h1;
  localparam logic [3:0]  RD_VECTOR     = 4'h2;
  localparam logic [3:0]  RD_PENDING    = 4'h3;
  localparam logic [3:0]  RD_MODE       = 4'h4;
  localparam logic [3:0]  RD_TX_PARAM   = 4'h5;
  localparam logic [3:0]  RD_CNT_LO     = 4'h6;
  localparam logic [3:0]  RD_CNT_HI     = 4'h7;
  localparam logic [3:0]  RD_RX_BUF     = 4'h8;
  localparam logic [3:0]  RD_RX_PARAM   = 4'h9;
  localparam logic [3:0]  RD_MISC_STAT  = 4'hA;
  localparam logic [3:0]  RD_MISC       = 4'hB;
  localparam logic [3:0]  RD_RATE_LO    = 4'hC;
  localparam logic [3:0]  RD_RATE_HI    = 4'hD;
  localparam logic [3:0]  RD_FEATURE    = 4'hE;
  localparam logic [3:0]  RD_EXT_STAT   = 4'hF;

  // Field positions.
  localparam int          EXT_READ_BIT  = 6;
  localparam int          FEAT_SEL_BIT  = 0;
  localparam int          FIFO_EN_BIT   = 2;
  localparam int          VIS_BIT       = 0;
  localparam int          VEC_CODE_LSB  = 1;
  localparam int          MODE_SYNC_LSB = 4;
  localparam logic [1:0]  MODE_BIT_SYNC = 2'h2;
  localparam int          CMD_LSB       = 3;
  localparam int          CRC_LSB       = 6;
  localparam logic [2:0]  CMD_NULL      = 3'h0;
  localparam logic [2:0]  CMD_POINT_HI  = 3'h1;
  localparam logic [1:0]  CRC_NULL      = 2'h0;

  // Reset values.
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [7:0]  MASTER_RST    = 8'h00;
  localparam logic [7:0]  VECTOR_RST    = 8'h00;

  typedef enum logic {VAR_POINTER, VAR_DIRECT} bus_variant_e;

  typedef struct packed {
    logic [7:0] rx_param;
    logic [7:0] mode;
    logic [7:0] tx_param;
    logic [7:0] misc;
    logic [7:0] rate_lo;
    logic [7:0] rate_hi;
    logic [7:0] feature;
    logic [7:0] ext_en;
  } chan_cfg_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] special;
    logic [7:0] rx_data;
    logic [7:0] misc_stat;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
  } chan_stat_s;

  typedef struct packed {
    logic [15:0][7:0] wr;
    logic [7:0]       feature;
  } chan_state_s;

  typedef struct packed {
    logic [7:0] master;
    logic [7:0] vector;
    logic [3:0] ptr;
    logic [7:0] rdata;
    logic       cmd_valid;
    logic       cmd_chan;
    logic [2:0] cmd_code;
    logic [1:0] crc_code;
    logic       tx_valid;
    logic       tx_chan;
    logic [7:0] tx_data;
  } top_state_s;

  function automatic logic ext_read(input chan_cfg_s c);
    return c.feature[EXT_READ_BIT];
  endfunction

  function automatic logic fifo_active(input chan_cfg_s c);
    return c.ext_en[FIFO_EN_BIT] && (c.mode[MODE_SYNC_LSB +: 2] == MODE_BIT_SYNC);
  endfunction

  function automatic logic is_shared(input logic [3:0] idx);
    return (idx == IDX_CMD) || (idx == IDX_VECTOR) || (idx == IDX_TX_BUF) ||
           (idx == IDX_MASTER);
  endfunction

endpackage
`default_nettype wire

// [rtl/chan_regs.sv]
`default_nettype none
module chan_regs (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  // Write port
  input  wire logic                     wr_i,
  input  wire logic [3:0]               idx_i,
  input  wire logic [7:0]               wdata_i,
  // Configuration
  output var serial_regs_pkg::chan_cfg_s cfg_o
);
  import serial_regs_pkg::*;

  chan_state_s st_r;
  chan_state_s st_nxt;

  // All eight bits are stored, reserved ones included, so they read back as written.
  always_comb begin
    st_nxt = st_r;
    if (wr_i) begin
      if (idx_i == IDX_FEATURE && st_r.wr[IDX_EXT_EN][FEAT_SEL_BIT]) begin
        st_nxt.feature = wdata_i;
      end else begin
        st_nxt.wr[idx_i] = wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{wr: {16{REG_RST}}, feature: REG_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_o = '{rx_param: st_r.wr[IDX_RX_PARAM], mode: st_r.wr[IDX_MODE],
                   tx_param: st_r.wr[IDX_TX_PARAM], misc: st_r.wr[IDX_MISC],
                   rate_lo: st_r.wr[IDX_RATE_LO], rate_hi: st_r.wr[IDX_RATE_HI],
                   feature: st_r.feature, ext_en: st_r.wr[IDX_EXT_EN]};

endmodule
`default_nettype wire

// [rtl/chan_read.sv]
`default_nettype none
module chan_read #(
  parameter bit IS_A = 1'b1
) (
  // Selection
  input  wire logic [3:0]                  idx_i,
  // Sources
  input  wire serial_regs_pkg::chan_cfg_s  cfg_i,
  input  wire serial_regs_pkg::chan_stat_s stat_i,
  input  wire logic [7:0]                  vector_i,
  input  wire logic                        vis_i,
  input  wire logic [2:0]                  irq_code_i,
  input  wire logic [serial_regs_pkg::PEND_W-1:0] pending_i,
  // Result
  output logic [7:0]                       byte_o
);
  import serial_regs_pkg::*;

  logic [7:0] mod_vec;

  always_comb begin
    mod_vec = vector_i;
    mod_vec[VEC_CODE_LSB +: 3] = irq_code_i;
    byte_o = 8'h00;
    case (idx_i)
      RD_STATUS:    byte_o = stat_i.status;
      RD_SPECIAL:   byte_o = stat_i.special;
      RD_VECTOR:    byte_o = (IS_A || !vis_i) ? vector_i : mod_vec;
      RD_PENDING:   if (IS_A) byte_o = {{(8-PEND_W){1'b0}}, pending_i};
      RD_MODE:      if (ext_read(cfg_i)) byte_o = cfg_i.mode;
      RD_TX_PARAM:  if (ext_read(cfg_i)) byte_o = cfg_i.tx_param;
      RD_CNT_LO:    if (fifo_active(cfg_i)) byte_o = stat_i.cnt_lo;
      RD_CNT_HI:    if (fifo_active(cfg_i)) byte_o = stat_i.cnt_hi;
      RD_RX_BUF:    byte_o = stat_i.rx_data;
      RD_RX_PARAM:  if (ext_read(cfg_i)) byte_o = cfg_i.rx_param;
      RD_MISC_STAT: byte_o = stat_i.misc_stat;
      RD_MISC:      if (ext_read(cfg_i)) byte_o = cfg_i.misc;
      RD_RATE_LO:   byte_o = cfg_i.rate_lo;
      RD_RATE_HI:   byte_o = cfg_i.rate_hi;
      RD_FEATURE:   if (ext_read(cfg_i)) byte_o = cfg_i.feature;
      RD_EXT_STAT:  byte_o = cfg_i.ext_en;
      default:      byte_o = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// [rtl/serial_reg_map.sv]
// Chosen here: the address-and-strobe port and the placing of the registers.
`default_nettype none
module serial_reg_map #(
  parameter serial_regs_pkg::bus_variant_e VARIANT = serial_regs_pkg::VAR_DIRECT
) (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  // Register port
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  wire logic                        chan_i,
  input  wire logic [3:0]                  addr_i,
  input  wire logic [7:0]                  wdata_i,
  output logic [7:0]                       rdata_o,
  // Status from the channel engines
  input  wire serial_regs_pkg::chan_stat_s stat_a_i,
  input  wire serial_regs_pkg::chan_stat_s stat_b_i,
  input  wire logic [serial_regs_pkg::PEND_W-1:0] pending_i,
  input  wire logic [2:0]                  irq_code_i,
  // Configuration to the channel engines
  output var   serial_regs_pkg::chan_cfg_s cfg_a_o,
  output var   serial_regs_pkg::chan_cfg_s cfg_b_o,
  output logic [7:0]                       master_o,
  output logic [7:0]                       vector_o,
  // Commands and transmit data
  output logic                             cmd_valid_o,
  output logic                             cmd_chan_o,
  output logic [2:0]                       cmd_code_o,
  output logic [1:0]                       crc_code_o,
  output logic                             tx_valid_o,
  output logic                             tx_chan_o,
  output logic [7:0]                       tx_data_o
);
  import serial_regs_pkg::*;

  top_state_s  st_r;
  top_state_s  st_nxt;
  logic [3:0]  eff_idx;
  logic        access;
  logic [2:0]  cmd_field;
  logic [1:0]  crc_field;
  chan_stat_s  stat  [NUM_CHAN];
  chan_cfg_s   cfg   [NUM_CHAN];
  logic [7:0]  rbyte [NUM_CHAN];
  logic        chan_wr [NUM_CHAN];

  assign stat[0] = stat_a_i;
  assign stat[1] = stat_b_i;
  assign access    = wr_i || rd_i;
  assign cmd_field = wdata_i[CMD_LSB +: 3];
  assign crc_field = wdata_i[CRC_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Slot selection. The pointer variant reaches every slot through the
  // command register; the direct variant takes the slot from the address.
  // Only the command decode and the pointer update differ, so everything else below is shared.
  ////////////////////////////////////////////////////////////////////////////
  assign eff_idx = (VARIANT == VAR_POINTER) ? st_r.ptr : addr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel storage and read selection.
  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    assign chan_wr[g] = wr_i && (chan_i == 1'(g)) && !is_shared(eff_idx);

    chan_regs u_regs (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wr_i      (chan_wr[g]),
      .idx_i     (eff_idx),
      .wdata_i   (wdata_i),
      .cfg_o     (cfg[g])
    );

    chan_read #(.IS_A(g == 0)) u_read (
      .idx_i      (eff_idx),
      .cfg_i      (cfg[g]),
      .stat_i     (stat[g]),
      .vector_i   (st_r.vector),
      .vis_i      (st_r.master[VIS_BIT]),
      .irq_code_i (irq_code_i),
      .pending_i  (pending_i),
      .byte_o     (rbyte[g])
    );
  end

  assign cfg_a_o = cfg[0];
  assign cfg_b_o = cfg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Shared registers, command decode and read data.
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt           = st_r;
    st_nxt.cmd_valid = 1'b0;
    st_nxt.tx_valid  = 1'b0;
    st_nxt.rdata     = rd_i ? rbyte[chan_i] : 8'h00;
    if (wr_i) begin
      case (eff_idx)
        IDX_MASTER: st_nxt.master = wdata_i;
        IDX_VECTOR: st_nxt.vector = wdata_i;
        IDX_TX_BUF: begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_chan  = chan_i;
          st_nxt.tx_data  = wdata_i;
        end
        IDX_CMD: begin
          // In the pointer variant point-high only extends the pointer; it reaches an engine only with a non-null reset code.
          if ((cmd_field != CMD_NULL && !(VARIANT == VAR_POINTER &&
               cmd_field == CMD_POINT_HI)) || crc_field != CRC_NULL) begin
            st_nxt.cmd_valid = 1'b1;
          end
          st_nxt.cmd_chan = chan_i;
          st_nxt.cmd_code = cmd_field;
          st_nxt.crc_code = crc_field;
        end
        default: begin
        end
      endcase
    end
    if (VARIANT == VAR_POINTER && access) begin
      // The pointer lasts for exactly one access, then falls back to slot 0.
      if (wr_i && eff_idx == IDX_CMD) begin
        st_nxt.ptr = {cmd_field == CMD_POINT_HI, wdata_i[2:0]};
      end else begin
        st_nxt.ptr = IDX_CMD;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{master: MASTER_RST, vector: VECTOR_RST, ptr: IDX_CMD,
                rdata: 8'h00, cmd_valid: 1'b0, cmd_chan: 1'b0, cmd_code: CMD_NULL,
                crc_code: CRC_NULL, tx_valid: 1'b0, tx_chan: 1'b0, tx_data: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o     = st_r.rdata;
  assign master_o    = st_r.master;
  assign vector_o    = st_r.vector;
  assign cmd_valid_o = st_r.cmd_valid;
  assign cmd_chan_o  = st_r.cmd_chan;
  assign cmd_code_o  = st_r.cmd_code;
  assign crc_code_o  = st_r.crc_code;
  assign tx_valid_o  = st_r.tx_valid;
  assign tx_chan_o   = st_r.tx_chan;
  assign tx_data_o   = st_r.tx_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////
  a_master_shared : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && eff_idx == IDX_MASTER) |=> (master_o == $past(wdata_i)))
    else $error("master register write from a channel was lost");

  a_vector_shared : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && chan_i && eff_idx == IDX_VECTOR) ##1 (rd_i && !chan_i && eff_idx == RD_VECTOR)
    |=> (rdata_o == $past(wdata_i, 2)))
    else $error("vector written via one channel not seen via the other");

  a_vector_plain : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && !chan_i && eff_idx == RD_VECTOR) |=> (rdata_o == $past(st_r.vector)))
    else $error("vector read via channel A was modified");

  a_vector_status : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && chan_i && eff_idx == RD_VECTOR && st_r.master[VIS_BIT])
    |=> (rdata_o[VEC_CODE_LSB +: 3] == $past(irq_code_i) &&
         rdata_o[7:4] == $past(st_r.vector[7:4])))
    else $error("vector read via channel B lacks status");

  a_pending_a_only : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && eff_idx == RD_PENDING) |=>
    (rdata_o == ($past(chan_i) ? 8'h00 : {{(8-PEND_W){1'b0}}, $past(pending_i)})))
    else $error("pending bits read wrong for the channel");

  a_ext_readback : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && eff_idx == RD_MODE) |=>
    (rdata_o == (ext_read($past(cfg[chan_i])) ? $past(cfg[chan_i].mode) : 8'h00)))
    else $error("mode readback does not follow the extended-read bit");

  a_count_gated : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && eff_idx == RD_CNT_LO && !fifo_active(cfg[chan_i])) |=> (rdata_o == 8'h00))
    else $error("frame count visible while frame FIFO inactive");

  a_rate_readback : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && eff_idx == IDX_RATE_HI) ##1 (rd_i && eff_idx == RD_RATE_HI &&
    chan_i == $past(chan_i)) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("rate constant high byte did not read back");

  a_chan_isolated : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && !chan_i) |=> $stable(cfg_b_o))
    else $error("write to channel A disturbed channel B");

endmodule
`default_nettype wire

// [verif/engine_model.sv]
`default_nettype none
module engine_model #(
  parameter serial_regs_pkg::chan_stat_s STAT_A = '0,
  parameter serial_regs_pkg::chan_stat_s STAT_B = '0,
  parameter logic [5:0]                  PEND   = 6'h00,
  parameter logic [2:0]                  CODE   = 3'h0
) (
  // Status levels towards the register map
  output var serial_regs_pkg::chan_stat_s stat_a_o,
  output var serial_regs_pkg::chan_stat_s stat_b_o,
  output var logic [5:0]                  pending_o,
  output var logic [2:0]                  irq_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import serial_regs_pkg::*;

  // The engines hold steady levels, so every readback has one known value.
  assign stat_a_o   = STAT_A;
  assign stat_b_o   = STAT_B;
  assign pending_o  = PEND;
  assign irq_code_o = CODE;
endmodule
`default_nettype wire

// [verif/serial_reg_map_tb.sv]
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module serial_reg_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_regs_pkg::*;

  localparam chan_stat_s STAT_A = 48'hA0_A1_A8_AA_A6_A7;
  localparam chan_stat_s STAT_B = 48'hB0_B1_B8_BA_B6_B7;
  localparam logic [5:0] PEND   = 6'h2D;
  localparam logic [2:0] CODE   = 3'h5;
  localparam logic       CH_A   = 1'b0;
  localparam logic       CH_B   = 1'b1;

  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       chan_i    = 1'b0;
  logic [3:0] addr_i    = 4'h0;
  logic [7:0] wdata_i   = 8'h00;
  logic [7:0] rdata_o;
  chan_stat_s stat_a;
  chan_stat_s stat_b;
  logic [5:0] pending;
  logic [2:0] irq_code;
  chan_cfg_s  cfg_a_o;
  chan_cfg_s  cfg_b_o;
  logic [7:0] master_o;
  logic [7:0] vector_o;
  logic       cmd_valid_o;
  logic       cmd_chan_o;
  logic [2:0] cmd_code_o;
  logic [1:0] crc_code_o;
  logic       tx_valid_o;
  logic       tx_chan_o;
  logic [7:0] tx_data_o;
  logic [7:0] rdata_ptr;
  logic       cmd_valid_ptr;
  chan_cfg_s  cfg_b_ptr;
  int         errors    = 0;
  int         n_checks  = 0;
  logic [3:0] ext_slot[5] = '{4'h9, 4'h4, 4'h5, 4'hB, 4'hE};
  logic [7:0] ext_val[5]  = '{8'h3C, 8'h20, 8'h6A, 8'h81, 8'h40};

  always #50 ref_clk_i = ~ref_clk_i;

  engine_model #(.STAT_A(STAT_A), .STAT_B(STAT_B), .PEND(PEND), .CODE(CODE)) engines (
    .stat_a_o(stat_a), .stat_b_o(stat_b), .pending_o(pending), .irq_code_o(irq_code));

  serial_reg_map dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .chan_i(chan_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .stat_a_i(stat_a),
    .stat_b_i(stat_b), .pending_i(pending), .irq_code_i(irq_code), .cfg_a_o(cfg_a_o),
    .cfg_b_o(cfg_b_o), .master_o(master_o), .vector_o(vector_o),
    .cmd_valid_o(cmd_valid_o), .cmd_chan_o(cmd_chan_o), .cmd_code_o(cmd_code_o),
    .crc_code_o(crc_code_o), .tx_valid_o(tx_valid_o), .tx_chan_o(tx_chan_o),
    .tx_data_o(tx_data_o));

  // Second copy in the pointer variant sees the same strobes but ignores the address.
  serial_reg_map #(.VARIANT(VAR_POINTER)) dut_ptr (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .chan_i(chan_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_ptr), .stat_a_i(stat_a),
    .stat_b_i(stat_b), .pending_i(pending), .irq_code_i(irq_code), .cfg_a_o(),
    .cfg_b_o(cfg_b_ptr), .master_o(), .vector_o(), .cmd_valid_o(cmd_valid_ptr),
    .cmd_chan_o(), .cmd_code_o(), .crc_code_o(), .tx_valid_o(), .tx_chan_o(),
    .tx_data_o());

  ////////////////////////////////////////////////////////////////////////////////
  // The task returns just after the sampling edge, so registered results are settled.
  task automatic wr(input logic ch, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    chan_i  <= ch;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic ch, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    chan_i <= ch;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask

  // A write and a read with no idle cycle between them.
  task automatic wr_rd(input logic wch, input logic [3:0] wa, input logic [7:0] d,
                       input logic rch, input logic [3:0] ra, input logic [7:0] e);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    chan_i  <= wch;
    addr_i  <= wa;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    chan_i  <= rch;
    addr_i  <= ra;
    @(posedge ref_clk_i);
    rd_i    <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 20000; i++) begin
      @(posedge ref_clk_i);
    end
    errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK(master_o, 8'h00)
    rd(CH_A, RD_VECTOR, 8'h00);
    wr(CH_B, IDX_MASTER, 8'h01);
    `CHK(master_o, 8'h01)
    wr(CH_A, IDX_MASTER, 8'h00);
    `CHK(master_o, 8'h00)
    wr(CH_B, IDX_VECTOR, 8'hF0);
    `CHK(vector_o, 8'hF0)
    wr(CH_A, IDX_VECTOR, 8'h96);
    `CHK(vector_o, 8'h96)
    rd(CH_B, RD_VECTOR, 8'h96);
    wr(CH_A, IDX_MASTER, 8'h01);
    rd(CH_B, RD_VECTOR, 8'h9A);
    rd(CH_A, RD_VECTOR, 8'h96);
    wr_rd(CH_B, IDX_VECTOR, 8'h5C, CH_A, RD_VECTOR, 8'h5C);
    rd(CH_A, RD_PENDING, {2'b00, PEND});
    rd(CH_B, RD_PENDING, 8'h00);
    // Extended readback stays hidden until the feature bit is set.
    wr(CH_A, IDX_RX_PARAM, 8'h3C);
    wr(CH_A, IDX_MODE, 8'h20);
    wr(CH_A, IDX_TX_PARAM, 8'h6A);
    wr(CH_A, IDX_MISC, 8'h81);
    for (int i = 0; i < 5; i++) begin
      rd(CH_A, ext_slot[i], 8'h00);
    end
    wr(CH_A, IDX_EXT_EN, 8'h01);
    wr(CH_A, IDX_FEATURE, 8'h40);
    `CHK(cfg_a_o.feature, 8'h40)
    for (int i = 0; i < 5; i++) begin
      rd(CH_A, ext_slot[i], ext_val[i]);
    end
    rd(CH_B, RD_RX_PARAM, 8'h00);
    `CHK(cfg_b_o, '0)
    rd(CH_A, RD_CNT_LO, 8'h00);
    wr(CH_A, IDX_EXT_EN, 8'h05);
    rd(CH_A, RD_EXT_STAT, 8'h05);
    rd(CH_A, RD_CNT_LO, STAT_A.cnt_lo);
    rd(CH_A, RD_CNT_HI, STAT_A.cnt_hi);
    rd(CH_B, RD_CNT_HI, 8'h00);
    wr(CH_A, IDX_MODE, 8'h10);
    rd(CH_A, RD_CNT_LO, 8'h00);
    wr(CH_A, IDX_RATE_LO, 8'hC3);
    wr(CH_A, IDX_RATE_HI, 8'h1E);
    wr(CH_B, IDX_RATE_LO, 8'h5A);
    `CHK(cfg_a_o.rate_lo, 8'hC3)
    `CHK(cfg_b_o.rate_lo, 8'h5A)
    rd(CH_A, RD_RATE_LO, 8'hC3);
    rd(CH_A, RD_RATE_HI, 8'h1E);
    rd(CH_B, RD_RATE_LO, 8'h5A);
    rd(CH_B, RD_RATE_HI, 8'h00);
    wr_rd(CH_B, IDX_RATE_HI, 8'hE1, CH_B, RD_RATE_HI, 8'hE1);
    rd(CH_B, RD_STATUS, STAT_B.status);
    rd(CH_A, RD_RX_BUF, STAT_A.rx_data);
    // Command codes 1 to 7, then reset codes 1 to 3, with the spare bits kept at zero.
    for (int c = 1; c < 8; c++) begin
      wr(c[0], IDX_CMD, {2'b00, c[2:0], 3'b000});
      `CHK(cmd_valid_o, 1'b1)
      `CHK(cmd_code_o, c[2:0])
      `CHK(cmd_chan_o, c[0])
    end
    for (int c = 1; c < 4; c++) begin
      wr(CH_A, IDX_CMD, {c[1:0], 6'h00});
      `CHK(crc_code_o, c[1:0])
    end
    @(posedge ref_clk_i);
    #1;
    `CHK(cmd_valid_o, 1'b0)
    wr(CH_B, IDX_TX_BUF, 8'hA5);
    `CHK({tx_valid_o, tx_chan_o, tx_data_o}, {2'b11, 8'hA5})
    // A reset in mid-run must clear the shared registers as well.
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    `CHK({master_o, vector_o}, 16'h0000)
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(CH_B, RD_VECTOR, 8'h00);
    // Point-high to slot 12: the pointer copy swallows it, the direct copy passes it on.
    wr(CH_B, IDX_CMD, 8'h0C);
    `CHK({cmd_valid_o, cmd_valid_ptr}, 2'b10)
    wr(CH_B, IDX_CMD, 8'h5A);
    `CHK(cfg_b_ptr.rate_lo, 8'h5A)
    wr(CH_B, IDX_CMD, 8'h0C);
    rd(CH_B, RD_RATE_LO, 8'h00);
    `CHK(rdata_ptr, 8'h5A)
    results();
  end
endmodule
`undef CHK
`default_nettype wire
